// file: logic/lgc_pkg.sv
/*
  Shared constants for the lane group controller and its fabric-side driver.
  Assumes one system clock CLOCK_IN at 40 MHz on both ends.
*/
package lgc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned REG_COUNT = 64;
  // Master clock source encodings
  localparam logic SRC_BANK_PLL = 1'b0;
  localparam logic SRC_FABRIC = 1'b1;
  // Calibration timing, in master clock edges
  localparam logic [7:0] INIT_CAL_EDGES = 8'h40;
  localparam logic [7:0] TRACK_CAL_EDGES = 8'h20;
  // Status register and its bits
  localparam logic [5:0] STATUS_ADDR = 6'h3F;
  localparam int unsigned ST_INIT_BIT = 0;
  localparam int unsigned ST_TRACK_BIT = 1;
  localparam int unsigned ST_SRC_BIT = 2;
  localparam int unsigned ST_BADSRC_BIT = 3;
  // Delay register that tracking holds constant
  localparam logic [5:0] DELAY_ADDR = 6'h00;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // Host register port offsets
  localparam logic [3:0] H_CTRL = 4'h0;
  localparam logic [3:0] H_ADDR = 4'h1;
  localparam logic [3:0] H_WDATA = 4'h2;
  localparam logic [3:0] H_CMD = 4'h3;
  localparam logic [3:0] H_RDATA = 4'h4;
  localparam logic [3:0] H_STATUS = 4'h5;
  localparam int unsigned CTRL_TRACK_BIT = 0;
  localparam int unsigned CTRL_SLICE_BIT = 1;
  localparam int unsigned CTRL_SRC_BIT = 2;
  localparam int unsigned CTRL_RX_BIT = 3;
  localparam int unsigned CMD_WR_BIT = 0;
  localparam int unsigned CMD_RD_BIT = 1;
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_INIT = 2'b01,
    CAL_WAIT = 2'b11,
    CAL_TRACK = 2'b10
  } lgc_cal_e;
endpackage

// file: logic/lgc_if.sv
/*
  Link between the lane group controller and the fabric logic.
  Assumes both ends sample the link pins with their own CLOCK_IN.
*/
interface lgc_if;
  logic bank_pll_clock;
  logic fabric_master_clock;
  logic master_clock_source_select;
  logic rx_only;
  logic reset_n;
  logic vt_tracking_enable;
  logic slice_tracking_enable;
  logic initial_cal_done;
  logic tracking_cal_done;
  logic register_port_clock;
  logic [5:0] register_port_address;
  logic [15:0] register_port_write_data;
  logic register_port_write_strobe;
  logic register_port_group_select;
  logic [15:0] register_port_read_bus;
  modport device (
    input bank_pll_clock, fabric_master_clock, master_clock_source_select, rx_only, reset_n,
    input vt_tracking_enable, slice_tracking_enable, register_port_clock, register_port_address,
    input register_port_write_data, register_port_write_strobe, register_port_group_select,
    output initial_cal_done, tracking_cal_done, register_port_read_bus
  );
  modport fabric (
    output bank_pll_clock, fabric_master_clock, master_clock_source_select, rx_only, reset_n,
    output vt_tracking_enable, slice_tracking_enable, register_port_clock, register_port_address,
    output register_port_write_data, register_port_write_strobe, register_port_group_select,
    input initial_cal_done, tracking_cal_done, register_port_read_bus
  );
endinterface

// file: logic/lgc_device.sv
/*
  Lane group controller: master clock selection, self-calibration sequence,
  tracking handshake, calibration status and a 64 x 16 register port.
  Assumes all link pins are asynchronous and are sampled by CLOCK_IN; the
  master and register port clocks are found by edge detection.
  // Overview of operation
  // - Fabric feeds exactly one master clock
  // - Unused master clock input held low
  // - Source select picks the connected clock
  // - Master clock paces self-calibration
  // - Bank clock comes from local PLL
  // - Bank PLL clock preferred, lower jitter
  // - Reset acts at once, released synchronously
  // - Tracking holds time-mode delays constant
  // - Fabric raises tracking after initial calibration
  // - Slice tracking enable kept high too
  // - Initial done output and status bit
  // - Tracking done output and status bit
  // - Tracking done sticks until reset/disable
  // - Register port has own clock
  // - Six-bit address, effect next port cycle
  // - Idle register address driven zero
  // - Sixty-four sixteen-bit registers
  // - Group select needed for any access
  // - Write strobe high to write
  // - Read data next port cycle
*/
// The address map and strobed register access were decided locally.
module lgc_device (
  // System
  input wire logic CLOCK_IN,
  input wire logic RESETN_IN,
  // Link
  lgc_if.device LINK,
  // Observation
  output logic [15:0] DELAY_VALUE_OUT,
  output logic MASTER_ACTIVE_OUT
);
  // Two-flop synchronisers for every link input
  logic [6:0] s1_q;
  logic [6:0] s2_q;
  logic [5:0] a1_q;
  logic [5:0] a2_q;
  logic [15:0] w1_q;
  logic [15:0] w2_q;
  logic rst1_q;
  logic rst2_q;
  logic [6:0] raw;
  assign raw = {LINK.bank_pll_clock, LINK.fabric_master_clock, LINK.master_clock_source_select,
    LINK.rx_only, LINK.vt_tracking_enable, LINK.slice_tracking_enable, LINK.register_port_clock};

  always_ff @(posedge CLOCK_IN)
  begin
    s1_q <= raw;
    s2_q <= s1_q;
    a1_q <= LINK.register_port_address;
    a2_q <= a1_q;
    w1_q <= LINK.register_port_write_data;
    w2_q <= w1_q;
  end

  // Reset asserts with no clock edge, release is synchronised
  always_ff @(posedge CLOCK_IN or negedge LINK.reset_n)
  begin
    if (!LINK.reset_n)
    begin
      rst1_q <= 1'b0;
      rst2_q <= 1'b0;
    end
    else
    begin
      rst1_q <= 1'b1;
      rst2_q <= rst1_q;
    end
  end

  logic rst_n;
  assign rst_n = RESETN_IN & rst2_q;
  logic pll_s, fab_s, src_s, rx_s, trk_s, slc_s, rck_s;
  assign {pll_s, fab_s, src_s, rx_s, trk_s, slc_s, rck_s} = s2_q;

  // Edges of the sampled clocks
  logic mclk_q;
  logic rck_q;
  logic grp1_q, grp2_q, wen1_q, wen2_q;
  logic mclk_sel;
  logic bad_src;
  assign mclk_sel = (src_s == lgc_pkg::SRC_FABRIC) ? fab_s : pll_s;
  assign bad_src = (src_s == lgc_pkg::SRC_FABRIC) ? (!rx_s || pll_s) : fab_s;
  logic mclk_rise;
  logic rck_rise;
  assign mclk_rise = mclk_sel & ~mclk_q;
  assign rck_rise = rck_s & ~rck_q;

  always_ff @(posedge CLOCK_IN)
  begin
    mclk_q <= mclk_sel;
    rck_q <= rck_s;
    grp1_q <= LINK.register_port_group_select;
    grp2_q <= grp1_q;
    wen1_q <= LINK.register_port_write_strobe;
    wen2_q <= wen1_q;
  end

  // Self-calibration sequencer on master clock edges
  lgc_pkg::lgc_cal_e cal_q;
  logic [7:0] cnt_q;
  logic init_done_q;
  logic track_done_q;
  logic active_q;

  always_ff @(posedge CLOCK_IN)
  begin
    if (!rst_n)
    begin
      cal_q <= lgc_pkg::CAL_IDLE;
      cnt_q <= 8'h00;
      init_done_q <= 1'b0;
      track_done_q <= 1'b0;
    end
    else if (mclk_rise && !bad_src)
    begin
      case (cal_q)
        lgc_pkg::CAL_IDLE:
        begin
          cal_q <= lgc_pkg::CAL_INIT;
          cnt_q <= 8'h00;
        end
        lgc_pkg::CAL_INIT:
        begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == lgc_pkg::INIT_CAL_EDGES - 8'h01)
          begin
            init_done_q <= 1'b1;
            cal_q <= lgc_pkg::CAL_WAIT;
            cnt_q <= 8'h00;
          end
        end
        lgc_pkg::CAL_WAIT:
        begin
          if (trk_s)
          begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q == lgc_pkg::TRACK_CAL_EDGES - 8'h01)
            begin
              track_done_q <= 1'b1;
              cal_q <= lgc_pkg::CAL_TRACK;
            end
          end
          else
          begin
            cnt_q <= 8'h00;
          end
        end
        lgc_pkg::CAL_TRACK:
        begin
          if (!trk_s)
          begin
            track_done_q <= 1'b0;
            cal_q <= lgc_pkg::CAL_WAIT;
            cnt_q <= 8'h00;
          end
        end
        default:
        begin
          cal_q <= lgc_pkg::CAL_IDLE;
        end
      endcase
    end
    else if (cal_q == lgc_pkg::CAL_TRACK && !trk_s)
    begin
      track_done_q <= 1'b0;
      cal_q <= lgc_pkg::CAL_WAIT;
      cnt_q <= 8'h00;
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (!rst_n)
      active_q <= 1'b0;
    else
      active_q <= mclk_rise ? !bad_src : active_q;
  end

  // Register file, accesses taken at register port clock edges
  logic [15:0] regs_q [lgc_pkg::REG_COUNT];
  logic [15:0] rd_q;
  logic [15:0] status_word;
  logic track_hold;
  assign track_hold = track_done_q & slc_s;
  assign status_word = {12'h000, bad_src, src_s, track_done_q, init_done_q};

  always_ff @(posedge CLOCK_IN)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < lgc_pkg::REG_COUNT; i++)
        regs_q[i] <= lgc_pkg::REG_RESET;
    end
    else if (rck_rise && grp2_q && wen2_q && a2_q != lgc_pkg::STATUS_ADDR)
    begin
      if (!(track_hold && a2_q == lgc_pkg::DELAY_ADDR))
        regs_q[a2_q] <= w2_q;
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (!rst_n)
      rd_q <= 16'h0000;
    else if (rck_rise && grp2_q && !wen2_q)
      rd_q <= (a2_q == lgc_pkg::STATUS_ADDR) ? status_word : regs_q[a2_q];
  end

  assign LINK.initial_cal_done = init_done_q;
  assign LINK.tracking_cal_done = track_done_q;
  assign LINK.register_port_read_bus = rd_q;
  assign DELAY_VALUE_OUT = regs_q[lgc_pkg::DELAY_ADDR];
  assign MASTER_ACTIVE_OUT = active_q;
endmodule

// file: logic/lgc_fabric.sv
/*
  Fabric-side driver of the lane group controller. Software orders it over
  a plain register port; it makes the master and register port clocks by
  division and drives the control pins.
  Assumes CLOCK_IN at 40 MHz and the controller on the other side of LINK.
*/
module lgc_fabric (
  // System
  input wire logic CLOCK_IN,
  input wire logic RESETN_IN,
  // Software port
  input wire logic [3:0] ADDR_IN,
  input wire logic [15:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [15:0] RDATA_OUT,
  // Link
  lgc_if.fabric LINK
);
  logic [3:0] ctrl_q;
  logic [5:0] addr_q;
  logic [15:0] wdata_q;
  logic [1:0] pend_q;
  logic [15:0] rbuf_q;
  logic [15:0] rdata_q;
  logic [2:0] div_q;
  logic rst_q;
  logic i1_q, i2_q, t1_q, t2_q;
  logic port_wen_q, port_sel_q;

  // Clock divider: master and register port clocks, CLOCK_IN / 8
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RESETN_IN)
      div_q <= 3'h0;
    else
      div_q <= div_q + 3'h1;
  end

  // Reset released synchronously
  always_ff @(posedge CLOCK_IN)
    rst_q <= RESETN_IN;

  // Calibration-ready outputs synchronised before use
  always_ff @(posedge CLOCK_IN)
  begin
    i1_q <= LINK.initial_cal_done;
    i2_q <= i1_q;
    t1_q <= LINK.tracking_cal_done;
    t2_q <= t1_q;
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (!RESETN_IN)
    begin
      ctrl_q <= 4'h8;
      addr_q <= 6'h00;
      wdata_q <= 16'h0000;
    end
    else if (WR_IN)
    begin
      case (ADDR_IN)
        lgc_pkg::H_CTRL: ctrl_q <= WDATA_IN[3:0];
        lgc_pkg::H_ADDR: addr_q <= WDATA_IN[5:0];
        lgc_pkg::H_WDATA: wdata_q <= WDATA_IN;
        default: ;
      endcase
    end
  end

  // Command held from one port clock fall to the next
  logic port_fall;
  assign port_fall = (div_q == 3'h7);
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RESETN_IN)
    begin
      pend_q <= 2'b00;
      port_wen_q <= 1'b0;
      port_sel_q <= 1'b0;
    end
    else
    begin
      if (WR_IN && ADDR_IN == lgc_pkg::H_CMD)
        pend_q <= pend_q | WDATA_IN[1:0];
      if (port_fall)
      begin
        port_sel_q <= |pend_q;
        port_wen_q <= pend_q[lgc_pkg::CMD_WR_BIT];
        pend_q <= (WR_IN && ADDR_IN == lgc_pkg::H_CMD) ? WDATA_IN[1:0] : 2'b00;
      end
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (!RESETN_IN)
      rbuf_q <= 16'h0000;
    else if (port_fall && port_sel_q && !port_wen_q)
      rbuf_q <= LINK.register_port_read_bus;
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RD_IN)
      rdata_q <= 16'h0000;
    else
    begin
      case (ADDR_IN)
        lgc_pkg::H_CTRL: rdata_q <= {12'h000, ctrl_q};
        lgc_pkg::H_ADDR: rdata_q <= {10'h000, addr_q};
        lgc_pkg::H_WDATA: rdata_q <= wdata_q;
        lgc_pkg::H_CMD: rdata_q <= {14'h0000, pend_q};
        lgc_pkg::H_RDATA: rdata_q <= rbuf_q;
        lgc_pkg::H_STATUS: rdata_q <= {14'h0000, t2_q, i2_q};
        default: rdata_q <= 16'h0000;
      endcase
    end
  end

  logic use_fab;
  assign use_fab = ctrl_q[lgc_pkg::CTRL_SRC_BIT];
  assign RDATA_OUT = rdata_q;
  assign LINK.bank_pll_clock = use_fab ? 1'b0 : div_q[2];
  assign LINK.fabric_master_clock = use_fab ? div_q[2] : 1'b0;
  assign LINK.master_clock_source_select = use_fab;
  assign LINK.rx_only = ctrl_q[lgc_pkg::CTRL_RX_BIT];
  assign LINK.reset_n = rst_q;
  assign LINK.vt_tracking_enable = ctrl_q[lgc_pkg::CTRL_TRACK_BIT] & i2_q;
  assign LINK.slice_tracking_enable = ctrl_q[lgc_pkg::CTRL_SLICE_BIT];
  assign LINK.register_port_clock = div_q[2];
  assign LINK.register_port_address = port_sel_q ? addr_q : 6'h00;
  assign LINK.register_port_write_data = port_wen_q ? wdata_q : 16'h0000;
  assign LINK.register_port_write_strobe = port_wen_q;
  assign LINK.register_port_group_select = port_sel_q;
endmodule

// file: tb/lgc_link_properties.sv
/*
  Link checker for the lane group controller and its fabric driver.
  Assumes CLOCK_IN samples every link signal on both ends.
*/
module lgc_link_properties (
  // System
  input wire logic CLOCK_IN,
  input wire logic RESETN_IN,
  // Clocks and control
  input wire logic bank_pll_clock,
  input wire logic fabric_master_clock,
  input wire logic master_clock_source_select,
  input wire logic reset_n,
  input wire logic vt_tracking_enable,
  // Status
  input wire logic initial_cal_done,
  input wire logic tracking_cal_done,
  // Register port
  input wire logic [5:0] register_port_address,
  input wire logic register_port_write_strobe,
  input wire logic register_port_group_select
);
  logic mclk_q;
  logic [7:0] edges_q;
  wire logic mclk = master_clock_source_select ? fabric_master_clock : bank_pll_clock;
  // Rising edges of the selected master clock since reset
  always_ff @(posedge CLOCK_IN)
  begin
    mclk_q <= mclk;
    if (!RESETN_IN || !reset_n)
      edges_q <= 8'h00;
    else if (mclk && !mclk_q && edges_q != 8'hFF)
      edges_q <= edges_q + 8'h01;
  end
  default clocking @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RESETN_IN || !reset_n);
  unused_clk_low_a: assert property (master_clock_source_select ? !bank_pll_clock : !fabric_master_clock)
    else $error("unused master clock not low");
  init_after_edges_a: assert property ($rose(initial_cal_done) |-> edges_q >= lgc_pkg::INIT_CAL_EDGES)
    else $error("initial calibration done too early");
  track_needs_init_a: assert property (tracking_cal_done |-> initial_cal_done)
    else $error("tracking done without initial done");
  track_rise_en_a: assert property ($rose(tracking_cal_done) |-> vt_tracking_enable)
    else $error("tracking done rose without enable");
  en_after_init_a: assert property ($rose(vt_tracking_enable) |-> initial_cal_done)
    else $error("tracking enable before initial done");
  track_sticky_a: assert property (vt_tracking_enable [*6] ##0 $past(tracking_cal_done) |-> tracking_cal_done)
    else $error("tracking done dropped while enabled");
  track_clear_a: assert property ($fell(vt_tracking_enable) |-> ##[1:8] !tracking_cal_done)
    else $error("tracking done not cleared");
  reset_clears_a: assert property (disable iff (!RESETN_IN)
    !reset_n |-> !initial_cal_done && !tracking_cal_done)
    else $error("status high during reset");
  write_select_a: assert property (register_port_write_strobe |-> register_port_group_select)
    else $error("write strobe without group select");
  idle_addr_zero_a: assert property (!register_port_group_select |-> register_port_address == 6'h00)
    else $error("idle register address not zero");
  addr_hold_a: assert property ($rose(register_port_group_select) |=> $stable(register_port_address) [*6])
    else $error("register address changed in command");
  cover property ($rose(initial_cal_done));
  cover property ($rose(tracking_cal_done));
  cover property ($fell(tracking_cal_done));
  cover property (register_port_write_strobe);
endmodule

// file: tb/test_io_lane_group_control_ports.sv
/*
  Bench for the lane group controller and its fabric driver.
  Assumes software reaches the fabric driver through its plain register port.
*/
module test_io_lane_group_control_ports;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst_n;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic [15:0] dly;
  logic mact;
  logic [15:0] q;
  logic [15:0] d;
  logic [15:0] d0;
  logic [5:0] a;
  int seed;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  lgc_if link_if();
  lgc_device u_lgc_device (.CLOCK_IN(clk), .RESETN_IN(rst_n), .LINK(link_if), .DELAY_VALUE_OUT(dly),
    .MASTER_ACTIVE_OUT(mact));
  lgc_fabric u_lgc_fabric (.CLOCK_IN(clk), .RESETN_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(rdata), .LINK(link_if));
  lgc_link_properties u_props (.CLOCK_IN(clk), .RESETN_IN(rst_n), .bank_pll_clock(link_if.bank_pll_clock),
    .fabric_master_clock(link_if.fabric_master_clock), .reset_n(link_if.reset_n),
    .master_clock_source_select(link_if.master_clock_source_select),
    .vt_tracking_enable(link_if.vt_tracking_enable), .initial_cal_done(link_if.initial_cal_done),
    .tracking_cal_done(link_if.tracking_cal_done), .register_port_address(link_if.register_port_address),
    .register_port_write_strobe(link_if.register_port_write_strobe),
    .register_port_group_select(link_if.register_port_group_select));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      give_verdict();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic sw_wr(input logic [3:0] ad, input logic [15:0] dt);
    addr <= ad;
    wdata <= dt;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic sw_rd(input logic [3:0] ad, output logic [15:0] dt);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    dt = rdata;
  endtask
  // One command on the register port, then fetch what it returned
  task automatic port_op(input logic [5:0] ad, input logic [15:0] dt, input logic wop, output logic [15:0] r);
    sw_wr(lgc_pkg::H_ADDR, {10'h000, ad});
    sw_wr(lgc_pkg::H_WDATA, dt);
    sw_wr(lgc_pkg::H_CMD, wop ? 16'h0001 : 16'h0002);
    repeat (40) @(posedge clk);
    sw_rd(lgc_pkg::H_RDATA, r);
  endtask
  task automatic wait_stat(input int b, input logic v);
    logic [15:0] s;
    int n;
    n = 0;
    sw_rd(lgc_pkg::H_STATUS, s);
    while (s[b] !== v && n < 300)
    begin
      n++;
      repeat (8) @(posedge clk);
      sw_rd(lgc_pkg::H_STATUS, s);
    end
    chk(16'(s[b]), 16'(v));
  endtask
  function automatic logic [15:0] stat_exp(input logic ini, input logic trk, input logic src, input logic bad);
    stat_exp = 16'h0000;
    stat_exp[lgc_pkg::ST_INIT_BIT] = ini;
    stat_exp[lgc_pkg::ST_TRACK_BIT] = trk;
    stat_exp[lgc_pkg::ST_SRC_BIT] = src;
    stat_exp[lgc_pkg::ST_BADSRC_BIT] = bad;
  endfunction
  initial
  begin
    seed = 89;
    rst_n <= 1'b0;
    addr <= 4'h0;
    wdata <= 16'h0000;
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(dly, lgc_pkg::REG_RESET);
    sw_rd(4'hF, q);
    chk(q, 16'h0000);
    wait_stat(lgc_pkg::ST_INIT_BIT, 1'b1);
    port_op(lgc_pkg::STATUS_ADDR, 16'hFFFF, 1'b1, q);
    port_op(lgc_pkg::STATUS_ADDR, 16'h0000, 1'b0, q);
    chk(q, stat_exp(1'b1, 1'b0, 1'b0, 1'b0));
    for (int i = 0; i < 6; i++)
    begin
      a = 6'(1 + ($unsigned($random(seed)) % 62));
      d = 16'($random(seed));
      port_op(a, d, 1'b1, q);
      port_op(a, 16'h0000, 1'b0, q);
      chk(q, d);
    end
    d0 = 16'($random(seed));
    port_op(lgc_pkg::DELAY_ADDR, d0, 1'b1, q);
    chk(dly, d0);
    sw_wr(lgc_pkg::H_CTRL, 16'h000B);
    wait_stat(lgc_pkg::ST_TRACK_BIT, 1'b1);
    port_op(lgc_pkg::STATUS_ADDR, 16'h0000, 1'b0, q);
    chk(q, stat_exp(1'b1, 1'b1, 1'b0, 1'b0));
    port_op(lgc_pkg::DELAY_ADDR, ~d0, 1'b1, q);
    chk(dly, d0);
    sw_wr(lgc_pkg::H_CTRL, 16'h000A);
    wait_stat(lgc_pkg::ST_TRACK_BIT, 1'b0);
    port_op(lgc_pkg::DELAY_ADDR, ~d0, 1'b1, q);
    chk(dly, ~d0);
    // Fabric clock without receive-only is refused
    sw_wr(lgc_pkg::H_CTRL, 16'h0004);
    repeat (100) @(posedge clk);
    port_op(lgc_pkg::STATUS_ADDR, 16'h0000, 1'b0, q);
    chk(q, stat_exp(1'b1, 1'b0, 1'b1, 1'b1));
    chk(16'(mact), 16'h0000);
    sw_wr(lgc_pkg::H_CTRL, 16'h000C);
    repeat (100) @(posedge clk);
    port_op(lgc_pkg::STATUS_ADDR, 16'h0000, 1'b0, q);
    chk(q, stat_exp(1'b1, 1'b0, 1'b1, 1'b0));
    chk(16'(mact), 16'h0001);
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    chk(16'(link_if.initial_cal_done), 16'h0000);
    chk(dly, lgc_pkg::REG_RESET);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    give_verdict();
  end
endmodule
